// File: inc/lac_defines.svh
// register indices, field positions, reset values and timing for the limit/alert block
// assumes a single 200 MHz clock and an 8-bit register port
`ifndef LAC_DEFINES_SVH
`define LAC_DEFINES_SVH

`define LAC_NREG        25
`define LAC_A_CFG       5'h00
`define LAC_A_RATE      5'h01
`define LAC_A_STAT_A    5'h02
`define LAC_A_STAT_B    5'h03
`define LAC_A_CHMASK    5'h04
`define LAC_A_INT_HI    5'h05
`define LAC_A_INT_LO    5'h06
`define LAC_A_EXT_HI    5'h07
`define LAC_A_EXT_LO    5'h08
`define LAC_A_CUR_HI    5'h09
`define LAC_A_CUR_LO    5'h0a
`define LAC_A_VS_HI     5'h0b
`define LAC_A_VS_LO     5'h0c
`define LAC_A_INT_CRIT  5'h0d
`define LAC_A_EXT_CRIT  5'h0e
`define LAC_A_THYST     5'h0f
`define LAC_A_CUR_CRIT  5'h10
`define LAC_A_VS_CRIT   5'h11
`define LAC_A_VHYST     5'h12
`define LAC_A_CONSEC    5'h13
`define LAC_A_REC       5'h14
`define LAC_A_IDEAL     5'h15
`define LAC_A_PEAK_DUR  5'h16
`define LAC_A_TEMP_INT  5'h17
`define LAC_A_TEMP_EXT  5'h18

// configuration bits
`define LAC_CFG_PEAK_LINK 3
`define LAC_CFG_DYN_AVG   4
`define LAC_CFG_COMP      5
`define LAC_CFG_MASK_ALL  7
// status A: [1:0] temp high, [3:2] temp low, 4 fault, 5 peak
// status B: [1:0] cur/vs high, [3:2] cur/vs low, 4 tcrit, 5 vcrit
`define LAC_ST_FAULT    4
`define LAC_ST_PEAK     5
`define LAC_ST_TCRIT    4
`define LAC_ST_VCRIT    5
`define LAC_MASK_PEAK   4

`define LAC_RST_HI      8'h55
`define LAC_RST_LO      8'h80
`define LAC_RST_CRIT    8'h64
`define LAC_RST_THYST   8'h0a
`define LAC_RST_VHI     8'h7f
`define LAC_RST_VHYST   8'h0a
`define LAC_RST_RATE    8'h06
`define LAC_RST_CONSEC  8'h11
`define LAC_RST_REC     8'h03
`define LAC_RST_IDEAL   8'h12
`define LAC_RST_DUR     8'h01
`define LAC_FAULT_TEMP  8'h80
`define LAC_SAT_MIN     8'h80

// rate codes and averaging factors
`define LAC_RATE_1PS    8'h04
`define LAC_RATE_2PS    8'h05
`define LAC_RATE_4PS    8'h06
`define LAC_AVG_16      5'h10
`define LAC_AVG_8       5'h08
`define LAC_AVG_4       5'h04
`define LAC_AVG_1       5'h01

`define LAC_CLK_NS      5
`define LAC_T_MS_NS     1000000
`define LAC_CYC_PER_MS  (`LAC_T_MS_NS / `LAC_CLK_NS)
`define LAC_FILTER_CYC  16

`endif

// File: inc/lac_pkg.sv
// state type of the limit/alert block
// assumes lac_defines.svh on the include path
`include "lac_defines.svh"
`default_nettype none

package lac_pkg;
    typedef struct packed {
        logic [`LAC_NREG-1:0][7:0] regs;
        logic [7:0]                st_a;
        logic [7:0]                st_b;
        logic [3:0]                comp_hi;
        logic [1:0]                tcrit;
        logic [1:0]                vcrit;
        logic [1:0][3:0]           cnt_a;
        logic [1:0][3:0]           cnt_c;
        logic [2:0]                sync;
        logic                      pk_over;
        logic [17:0]               ms_cnt;
        logic [7:0]                pk_timer;
        logic [15:0]               pk_filt;
        logic                      pk_flag;
        logic                      alert;
        logic                      crit;
        logic [7:0]                rdata;
        logic [4:0]                avg;
    } lac_state_t;
endpackage

`default_nettype wire

// File: rtl/lac_limit_alert.sv
// limit checking, maskable alert and unmaskable critical outputs
// assumes measurement results arrive with a one-cycle valid on clk_i; peak_over_i is async
// How it works
// - one config bit picks latched interrupt or hysteretic comparator alert
// - mode affects high limits, the global mask and the peak link; low limits and faults always latch
// - interrupt mode: temp at/above high or below low, after consecutive count
// - interrupt mode: diode open or short also asserts alert
// - interrupt mode: current or source voltage out of limit asserts alert
// - alert holds while violating, then until status bits are cleared
// - global mask deasserts alert at once and holds it until cleared
// - masked violations still set their status bits, except comparator-mode high bits of channel-masked channels
// - interrupt mode: a current peak never asserts alert
// - comparator: temp at high asserts; release below high minus temp hysteresis
// - comparator: current/voltage at high asserts; release below high minus vhyst
// - comparator: high status bits follow alert, read-clear ignored, auto clear
// - comparator: global mask ignored, channel masks still gate events
// - comparator: linked peak detector asserts alert
// - critical out: temp at crit for count; release below crit minus hysteresis
// - critical out follows peak flag: set after peak duration over threshold, held until under past filter time
// - critical out: current/voltage at crit; release below crit minus vhyst
// - series resistance correction enable per diode channel
// - one ideality setting per external diode, nominal 1.008
// - dynamic averaging: 16x, 8x, 4x, 1x by rate; disabled gives 1x
// - diode fault forces temp high byte to 80h and sets fault status
// - peak timer resets only after current stays under past filter time
//
// Our own choices: the register addresses and the strobed register port.
`include "lac_defines.svh"
`default_nettype none

module lac_limit_alert
    import lac_pkg::*;
#(
    parameter int CYC_PER_MS = `LAC_CYC_PER_MS,  // cycles per millisecond
    parameter int FILTER_CYC = `LAC_FILTER_CYC   // peak filter interval in cycles
) (
    input  wire logic       clk_i,          // 200 MHz clock
    input  wire logic       rstn_i,         // async reset, active low
    input  wire logic [4:0] addr_i,         // register address
    input  wire logic [7:0] wdata_i,        // write data
    input  wire logic       we_i,           // write strobe
    input  wire logic       re_i,           // read strobe
    output logic      [7:0] rdata_o,        // read data, cycle after re_i
    input  wire logic       meas_valid_i,   // new results this cycle
    input  wire logic [7:0] temp_int_i,     // internal diode temp, signed
    input  wire logic [7:0] temp_ext_i,     // external diode temp, signed
    input  wire logic [7:0] current_i,      // sense result, signed
    input  wire logic [7:0] vsource_i,      // source voltage result, signed
    input  wire logic       diode_fault_i,  // external diode open/short
    input  wire logic       peak_over_i,    // instantaneous over-threshold, async
    output logic            alert_out_o,    // alert pin level when driven
    output logic            alert_oen_o,    // low while alert pulled low
    output logic            crit_out_o,     // critical_out level when driven
    output logic            crit_oen_o,     // low while critical_out pulled low
    output logic      [7:0] temp_ext_o,     // external temp high byte
    output logic      [1:0] series_resistance_correction_o, // per channel enable
    output logic      [7:0] ideality_o,     // ideality setting, external diode
    output logic      [4:0] avg_factor_o    // conversion averaging factor
);

    lac_state_t s;
    lac_state_t next_s;

    function automatic logic ge(input logic [7:0] a, input logic [7:0] b);
        return $signed(a) >= $signed(b);
    endfunction

    // saturating release threshold; a wrap would make release come too early
    function automatic logic [7:0] rel_thr(input logic [7:0] lim, input logic [7:0] hyst);
        logic signed [9:0] d;
        // ten bits: limit -128 minus hysteresis ffh must not wrap positive
        d = $signed({{2{lim[7]}}, lim}) - $signed({2'b00, hyst});
        return (d < -10'sd128) ? `LAC_SAT_MIN : d[7:0];
    endfunction

    function automatic logic [3:0] inc_sat(input logic [3:0] c);
        return (c == 4'hf) ? c : c + 4'h1;
    endfunction

    function automatic logic reached(input logic [3:0] c, input logic [3:0] req);
        return (req == 4'h0) || (c >= req);
    endfunction

    function automatic logic writable(input logic [4:0] a);
        return (a < 5'(`LAC_NREG)) && (a != `LAC_A_STAT_A) && (a != `LAC_A_STAT_B)
               && (a != `LAC_A_TEMP_INT) && (a != `LAC_A_TEMP_EXT);
    endfunction

    function automatic lac_state_t rst_state();
        lac_state_t r;
        r = '0;
        r.regs[`LAC_A_RATE]     = `LAC_RST_RATE;
        r.regs[`LAC_A_INT_HI]   = `LAC_RST_HI;
        r.regs[`LAC_A_INT_LO]   = `LAC_RST_LO;
        r.regs[`LAC_A_EXT_HI]   = `LAC_RST_HI;
        r.regs[`LAC_A_EXT_LO]   = `LAC_RST_LO;
        r.regs[`LAC_A_CUR_HI]   = `LAC_RST_VHI;
        r.regs[`LAC_A_CUR_LO]   = `LAC_RST_LO;
        r.regs[`LAC_A_VS_HI]    = `LAC_RST_VHI;
        r.regs[`LAC_A_VS_LO]    = `LAC_RST_LO;
        r.regs[`LAC_A_INT_CRIT] = `LAC_RST_CRIT;
        r.regs[`LAC_A_EXT_CRIT] = `LAC_RST_CRIT;
        r.regs[`LAC_A_THYST]    = `LAC_RST_THYST;
        r.regs[`LAC_A_CUR_CRIT] = `LAC_RST_VHI;
        r.regs[`LAC_A_VS_CRIT]  = `LAC_RST_VHI;
        r.regs[`LAC_A_VHYST]    = `LAC_RST_VHYST;
        r.regs[`LAC_A_CONSEC]   = `LAC_RST_CONSEC;
        r.regs[`LAC_A_REC]      = `LAC_RST_REC;
        r.regs[`LAC_A_IDEAL]    = `LAC_RST_IDEAL;
        r.regs[`LAC_A_PEAK_DUR] = `LAC_RST_DUR;
        r.avg                   = `LAC_AVG_1;
        return r;
    endfunction

    localparam lac_state_t RST_STATE = rst_state();

    logic       comp;
    logic       mask_all;
    logic       link;
    logic [7:0] cfg;
    logic [7:0] um;
    logic [7:0] val;
    logic [7:0] hi_lim;
    logic [7:0] lo_lim;
    logic [7:0] cr_lim;
    logic       hv;
    logic       lv;
    logic       cv;
    logic       lat;
    logic       hi_lat;
    logic [7:0] rate;

    always_comb
    begin
        next_s   = s;
        val      = 8'h00;
        hi_lim   = 8'h00;
        lo_lim   = 8'h00;
        cr_lim   = 8'h00;
        hv       = 1'b0;
        lv       = 1'b0;
        cv       = 1'b0;
        next_s.rdata = 8'h00;

        // register port
        if (we_i && writable(addr_i))
        begin
            next_s.regs[addr_i] = wdata_i;
        end
        cfg      = next_s.regs[`LAC_A_CFG];
        comp     = cfg[`LAC_CFG_COMP];
        mask_all = cfg[`LAC_CFG_MASK_ALL];
        link     = cfg[`LAC_CFG_PEAK_LINK];
        um       = ~next_s.regs[`LAC_A_CHMASK];
        if (re_i)
        begin
            if (addr_i == `LAC_A_STAT_A)
            begin
                next_s.rdata = s.st_a;
                // high bits survive reads in comparator mode
                next_s.st_a  = s.st_a & (comp ? 8'h03 : 8'h00);
            end
            else if (addr_i == `LAC_A_STAT_B)
            begin
                next_s.rdata = s.st_b;
                next_s.st_b  = s.st_b & (comp ? 8'h03 : 8'h00);
            end
            else if (addr_i < 5'(`LAC_NREG))
            begin
                next_s.rdata = s.regs[addr_i];
            end
        end

        // limit checks; sets come after the read clear so a set wins
        if (meas_valid_i)
        begin
            next_s.regs[`LAC_A_TEMP_INT] = temp_int_i;
            next_s.regs[`LAC_A_TEMP_EXT] = diode_fault_i ? `LAC_FAULT_TEMP
                                                         : temp_ext_i;
            if (diode_fault_i)
            begin
                next_s.st_a[`LAC_ST_FAULT] = 1'b1;
            end
            for (int c = 0; c < 2; c++)
            begin
                // temperature channel c
                val    = (c == 0) ? temp_int_i : temp_ext_i;
                hi_lim = next_s.regs[`LAC_A_INT_HI + 2 * c];
                lo_lim = next_s.regs[`LAC_A_INT_LO + 2 * c];
                cr_lim = next_s.regs[`LAC_A_INT_CRIT + c];
                hv     = ge(val, hi_lim);
                lv     = !ge(val, lo_lim);
                cv     = ge(val, cr_lim);
                if (c == 1 && diode_fault_i)
                begin
                    hv = 1'b0;
                    lv = 1'b0;
                    cv = 1'b0;
                end
                next_s.cnt_a[c] = (hv || lv) ? inc_sat(s.cnt_a[c]) : 4'h0;
                if ((hv || lv) && reached(next_s.cnt_a[c], next_s.regs[`LAC_A_CONSEC][3:0]))
                begin
                    // status updates ignore every mask
                    if (hv && !comp)
                        next_s.st_a[c] = 1'b1;
                    if (lv)
                        next_s.st_a[2 + c] = 1'b1;
                end
                if (hv && um[c])
                    next_s.comp_hi[c] = 1'b1;
                else if (!ge(val, rel_thr(hi_lim, next_s.regs[`LAC_A_THYST])))
                    next_s.comp_hi[c] = 1'b0;
                next_s.cnt_c[c] = cv ? inc_sat(s.cnt_c[c]) : 4'h0;
                if (cv && reached(next_s.cnt_c[c], next_s.regs[`LAC_A_CONSEC][7:4]))
                begin
                    next_s.tcrit[c]            = 1'b1;
                    next_s.st_b[`LAC_ST_TCRIT] = 1'b1;
                end
                else if (!ge(val, rel_thr(cr_lim, next_s.regs[`LAC_A_THYST])))
                    next_s.tcrit[c] = 1'b0;

                // current (c=0) or source voltage (c=1)
                val    = (c == 0) ? current_i : vsource_i;
                hi_lim = next_s.regs[`LAC_A_CUR_HI + 2 * c];
                lo_lim = next_s.regs[`LAC_A_CUR_LO + 2 * c];
                cr_lim = next_s.regs[`LAC_A_CUR_CRIT + c];
                hv     = ge(val, hi_lim);
                lv     = !ge(val, lo_lim);
                if (hv && !comp)
                    next_s.st_b[c] = 1'b1;
                if (lv)
                    next_s.st_b[2 + c] = 1'b1;
                if (hv && um[2 + c])
                    next_s.comp_hi[2 + c] = 1'b1;
                else if (!ge(val, rel_thr(hi_lim, next_s.regs[`LAC_A_VHYST])))
                    next_s.comp_hi[2 + c] = 1'b0;
                if (ge(val, cr_lim))
                begin
                    next_s.vcrit[c]            = 1'b1;
                    next_s.st_b[`LAC_ST_VCRIT] = 1'b1;
                end
                else if (!ge(val, rel_thr(cr_lim, next_s.regs[`LAC_A_VHYST])))
                    next_s.vcrit[c] = 1'b0;
            end
        end

        // comparator state is meaningless in interrupt mode
        if (!comp)
            next_s.comp_hi = 4'h0;
        else
        begin
            next_s.st_a[1:0] = next_s.comp_hi[1:0];
            next_s.st_b[1:0] = next_s.comp_hi[3:2];
        end

        // peak detector, three-stage synchroniser
        next_s.sync = {s.sync[1:0], peak_over_i};
        if (s.sync[1] == s.sync[2])
            next_s.pk_over = s.sync[2];
        next_s.ms_cnt = (s.ms_cnt >= 18'(CYC_PER_MS - 1)) ? 18'h0 : s.ms_cnt + 18'h1;
        if (s.pk_over)
        begin
            next_s.pk_filt = 16'h0;
            if (s.ms_cnt == 18'h0 && s.pk_timer != 8'hff)
                next_s.pk_timer = s.pk_timer + 8'h1;
            if (s.pk_timer >= next_s.regs[`LAC_A_PEAK_DUR])
                next_s.pk_flag = 1'b1;
        end
        else if (s.pk_filt >= 16'(FILTER_CYC))
        begin
            // under threshold longer than the filter interval
            next_s.pk_timer = 8'h0;
            next_s.pk_flag  = 1'b0;
        end
        else
            next_s.pk_filt = s.pk_filt + 16'h1;
        next_s.st_a[`LAC_ST_PEAK] = next_s.pk_flag;

        // output decisions
        lat    = (|(next_s.st_a[3:2] & um[1:0])) | (|(next_s.st_b[3:2] & um[3:2]))
                 | next_s.st_a[`LAC_ST_FAULT];
        hi_lat = (|(next_s.st_a[1:0] & um[1:0])) | (|(next_s.st_b[1:0] & um[3:2]));
        if (comp)
            next_s.alert = lat | (|next_s.comp_hi)
                           | (link & next_s.pk_flag & um[`LAC_MASK_PEAK]);
        else
            next_s.alert = !mask_all && (lat || hi_lat);
        next_s.crit = (|next_s.tcrit) | (|next_s.vcrit) | next_s.pk_flag;

        rate = next_s.regs[`LAC_A_RATE];
        if (!cfg[`LAC_CFG_DYN_AVG])
            next_s.avg = `LAC_AVG_1;
        else if (rate <= `LAC_RATE_1PS)
            next_s.avg = `LAC_AVG_16;
        else if (rate == `LAC_RATE_2PS)
            next_s.avg = `LAC_AVG_8;
        else if (rate == `LAC_RATE_4PS)
            next_s.avg = `LAC_AVG_4;
        else
            next_s.avg = `LAC_AVG_1;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            s <= RST_STATE;
        else
            s <= next_s;
    end

    assign rdata_o      = s.rdata;
    assign alert_out_o  = 1'b0;
    assign alert_oen_o  = !s.alert;
    assign crit_out_o   = 1'b0;
    assign crit_oen_o   = !s.crit;  // critical_out has no mask
    assign temp_ext_o   = s.regs[`LAC_A_TEMP_EXT];
    assign series_resistance_correction_o = s.regs[`LAC_A_REC][1:0];
    assign ideality_o   = s.regs[`LAC_A_IDEAL];  // avoid changing under beta comp
    assign avg_factor_o = s.avg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    mask_hold_a: assert property (
        !s.regs[`LAC_A_CFG][`LAC_CFG_COMP] && s.regs[`LAC_A_CFG][`LAC_CFG_MASK_ALL]
        |-> alert_oen_o)
        else $error("alert driven while globally masked");

    fault_force_a: assert property (
        meas_valid_i && diode_fault_i |=> temp_ext_o == 8'h80 && s.st_a[`LAC_ST_FAULT])
        else $error("diode fault not reflected");

    fault_alert_a: assert property (
        s.st_a[`LAC_ST_FAULT] && !s.regs[`LAC_A_CFG][`LAC_CFG_MASK_ALL] |-> !alert_oen_o)
        else $error("fault status without alert");

    peak_crit_a: assert property (
        s.pk_flag |-> !crit_oen_o && s.st_a[`LAC_ST_PEAK])
        else $error("peak flag without critical out");

    peak_filter_a: assert property (
        $fell(s.pk_flag) |-> $past(s.pk_filt) >= 16'(FILTER_CYC) && !$past(s.pk_over))
        else $error("peak released before filter interval");

    comp_status_a: assert property (
        s.regs[`LAC_A_CFG][`LAC_CFG_COMP] |-> s.st_a[1:0] == s.comp_hi[1:0])
        else $error("comparator status mismatch");

    avg_off_a: assert property (
        !s.regs[`LAC_A_CFG][`LAC_CFG_DYN_AVG] ##1 !s.regs[`LAC_A_CFG][`LAC_CFG_DYN_AVG]
        |-> avg_factor_o == 5'h01)
        else $error("averaging active while disabled");

    masked_set_a: assert property (
        meas_valid_i && !re_i && $signed(temp_int_i) < $signed(s.regs[`LAC_A_INT_LO])
        && !we_i && s.regs[`LAC_A_CONSEC][3:0] <= 4'h1 |=> s.st_a[2])
        else $error("low violation lost");

    read_rdata_a: assert property (
        !re_i |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");

    alert_comp_c: cover property (s.regs[`LAC_A_CFG][`LAC_CFG_COMP] && !alert_oen_o);
    alert_int_c:  cover property (!s.regs[`LAC_A_CFG][`LAC_CFG_COMP] && !alert_oen_o);
    crit_tmp_c:   cover property (|s.tcrit && !crit_oen_o);
    peak_c:       cover property ($rose(s.pk_flag));
    link_peak_c:  cover property (s.regs[`LAC_A_CFG][`LAC_CFG_PEAK_LINK] && s.pk_flag
                                  && !alert_oen_o);

endmodule

`default_nettype wire

// File: tb/lac_limit_alert_tb.sv
// bench for the limit/alert block: register port tasks and flag pin checks
// assumes the pin model's pull-ups and shortened ms and filter counts
`include "lac_defines.svh"
`default_nettype none

module lac_limit_alert_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i, rstn_i, we_i, re_i, mv, flt, pk;
    logic [4:0] addr_i;
    logic [7:0] wdata_i, ti, te, cu, vs;
    logic [7:0] rdata_o, text_o, ideal_o;
    logic [1:0] src_o;
    logic [4:0] avg_o;
    logic       aout, aoen, cout, coen, alert_n, crit_n;
    int         n_errors, n_checks;

    lac_limit_alert #(.CYC_PER_MS(10), .FILTER_CYC(4)) u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .meas_valid_i(mv),
        .temp_int_i(ti), .temp_ext_i(te), .current_i(cu), .vsource_i(vs),
        .diode_fault_i(flt), .peak_over_i(pk), .alert_out_o(aout),
        .alert_oen_o(aoen), .crit_out_o(cout), .crit_oen_o(coen),
        .temp_ext_o(text_o), .series_resistance_correction_o(src_o),
        .ideality_o(ideal_o), .avg_factor_o(avg_o));
    lac_pin_model u_pins (.alert_out_i(aout), .alert_oen_i(aoen), .crit_out_i(cout),
        .crit_oen_i(coen), .alert_n_o(alert_n), .crit_n_o(crit_n));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
        n_checks++;
        if (seen !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
        #1;
    endtask

    // read data lives only in the cycle after the strobe
    task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 chk(nm, rdata_o, e);
    endtask

    task automatic meas(input logic [7:0] i, x, c, v, input logic f);
        @(posedge clk_i);
        {mv, ti, te, cu, vs, flt} <= {1'b1, i, x, c, v, f};
        @(posedge clk_i);
        mv <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic pins(input string nm, input logic a, input logic c);
        chk({nm, " alert"}, {7'h00, alert_n}, {7'h00, a});
        chk({nm, " crit"}, {7'h00, crit_n}, {7'h00, c});
    endtask

    task automatic wait_crit(input logic v);
        for (int i = 0; i < 100 && crit_n !== v; i++) @(posedge clk_i);
        #1;
    endtask

    task automatic done(input string nm);
        $display("test %s ended, mismatches so far %0d", nm, n_errors);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_errors++;
        wrap_up();
    end

    initial
    begin
        {rstn_i, we_i, re_i, mv, flt, pk, addr_i, wdata_i, ti, te, cu, vs} = '0;
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd("rate", `LAC_A_RATE, 8'h06);
        rd("consec", `LAC_A_CONSEC, 8'h11);
        rd("ideal", `LAC_A_IDEAL, 8'h12);
        rd("unmapped", 5'h1f, 8'h00);
        chk("src rst", {6'h00, src_o}, 8'h03);
        wr(`LAC_A_REC, 8'h02);
        wr(`LAC_A_IDEAL, 8'h2c);
        chk("src one", {6'h00, src_o}, 8'h02);
        chk("ideal out", ideal_o, 8'h2c);
        wr(`LAC_A_CHMASK, 8'h00);
        wr(`LAC_A_CONSEC, 8'h00);
        done("reset");
        // interrupt mode: low, high, current limits latch until read
        wr(`LAC_A_INT_LO, 8'h10);
        meas(8'h05, 8'h20, 8'h00, 8'h00, 1'b0);
        pins("low", 1'b0, 1'b1);
        meas(8'h20, 8'h20, 8'h00, 8'h00, 1'b0);
        pins("low held", 1'b0, 1'b1);
        rd("st low", `LAC_A_STAT_A, 8'h04);
        repeat (2) @(posedge clk_i);
        pins("low clr", 1'b1, 1'b1);
        meas(8'h55, 8'h20, 8'h00, 8'h00, 1'b0);
        pins("high", 1'b0, 1'b1);
        meas(8'h20, 8'h20, 8'h7f, 8'h00, 1'b0);
        pins("cur", 1'b0, 1'b0);
        meas(8'h20, 8'h20, 8'h76, 8'h00, 1'b0);
        chk("vcrit hold", {7'h00, crit_n}, 8'h00);
        meas(8'h20, 8'h20, 8'h74, 8'h00, 1'b0);
        chk("vcrit rel", {7'h00, crit_n}, 8'h01);
        rd("st a hi", `LAC_A_STAT_A, 8'h01);
        rd("st b cur", `LAC_A_STAT_B, 8'h21);
        repeat (2) @(posedge clk_i);
        pins("cur clr", 1'b1, 1'b1);
        done("interrupt");
        meas(8'h05, 8'h20, 8'h00, 8'h00, 1'b0);
        wr(`LAC_A_CFG, 8'h80);
        pins("mask", 1'b1, 1'b1);
        meas(8'h05, 8'h20, 8'h00, 8'h00, 1'b0);
        pins("mask held", 1'b1, 1'b1);
        meas(8'h20, 8'h20, 8'h00, 8'h00, 1'b0);
        wr(`LAC_A_CFG, 8'h00);
        pins("unmask", 1'b0, 1'b1);
        rd("st masked", `LAC_A_STAT_A, 8'h04);
        done("mask");
        meas(8'h20, 8'h20, 8'h00, 8'h00, 1'b1);
        chk("fault temp", text_o, 8'h80);
        pins("fault", 1'b0, 1'b1);
        meas(8'h20, 8'h20, 8'h00, 8'h00, 1'b0);
        rd("st fault", `LAC_A_STAT_A, 8'h10);
        done("fault");
        // comparator: release below high minus 0a, status mirrors pin
        wr(`LAC_A_CFG, 8'h20);
        wr(`LAC_A_INT_HI, 8'h30);
        meas(8'h30, 8'h20, 8'h00, 8'h00, 1'b0);
        chk("cmp set", {7'h00, alert_n}, 8'h00);
        rd("cmp st", `LAC_A_STAT_A, 8'h01);
        rd("cmp st kept", `LAC_A_STAT_A, 8'h01);
        meas(8'h26, 8'h20, 8'h00, 8'h00, 1'b0);
        chk("cmp hold", {7'h00, alert_n}, 8'h00);
        meas(8'h25, 8'h20, 8'h00, 8'h00, 1'b0);
        chk("cmp rel", {7'h00, alert_n}, 8'h01);
        rd("cmp st clr", `LAC_A_STAT_A, 8'h00);
        wr(`LAC_A_CFG, 8'ha0);
        meas(8'h30, 8'h20, 8'h00, 8'h00, 1'b0);
        chk("cmp mask", {7'h00, alert_n}, 8'h00);
        meas(8'h20, 8'h20, 8'h7f, 8'h00, 1'b0);
        chk("cmp cur", {7'h00, alert_n}, 8'h00);
        meas(8'h20, 8'h20, 8'h74, 8'h00, 1'b0);
        chk("cmp cur rel", {7'h00, alert_n}, 8'h01);
        wr(`LAC_A_CHMASK, 8'h01);
        meas(8'h30, 8'h20, 8'h00, 8'h00, 1'b0);
        chk("ch mask", {7'h00, alert_n}, 8'h01);
        wr(`LAC_A_CHMASK, 8'h00);
        done("comparator");
        wr(`LAC_A_CFG, 8'h00);
        meas(8'h20, 8'h64, 8'h00, 8'h00, 1'b0);
        chk("tcrit", {7'h00, crit_n}, 8'h00);
        meas(8'h20, 8'h5a, 8'h00, 8'h00, 1'b0);
        chk("tcrit hold", {7'h00, crit_n}, 8'h00);
        meas(8'h20, 8'h59, 8'h00, 8'h00, 1'b0);
        chk("tcrit rel", {7'h00, crit_n}, 8'h01);
        rd("st b crit", `LAC_A_STAT_B, 8'h30);
        rd("st a crit", `LAC_A_STAT_A, 8'h02);
        done("critical");
        wr(`LAC_A_CFG, 8'h10);
        wr(`LAC_A_RATE, `LAC_RATE_1PS);
        chk("avg16", {3'h0, avg_o}, 8'h10);
        wr(`LAC_A_RATE, `LAC_RATE_2PS);
        chk("avg8", {3'h0, avg_o}, 8'h08);
        wr(`LAC_A_RATE, `LAC_RATE_4PS);
        chk("avg4", {3'h0, avg_o}, 8'h04);
        wr(`LAC_A_RATE, 8'h07);
        chk("avg1", {3'h0, avg_o}, 8'h01);
        wr(`LAC_A_RATE, `LAC_RATE_1PS);
        wr(`LAC_A_CFG, 8'h00);
        chk("avg off", {3'h0, avg_o}, 8'h01);
        done("averaging");
        @(posedge clk_i) pk <= 1'b1;
        wait_crit(1'b0);
        pins("peak", 1'b1, 1'b0);
        rd("st peak", `LAC_A_STAT_A, 8'h20);
        @(posedge clk_i) pk <= 1'b0;
        wait_crit(1'b1);
        chk("peak rel", {7'h00, crit_n}, 8'h01);
        wr(`LAC_A_CFG, 8'h28);
        @(posedge clk_i) pk <= 1'b1;
        wait_crit(1'b0);
        pins("peak link", 1'b0, 1'b0);
        @(posedge clk_i) pk <= 1'b0;
        done("peak");
        wrap_up();
    end
endmodule

`default_nettype wire

// File: tb/lac_pin_model.sv
// far side of the two open-drain flag pins: pull-ups and the wired level seen
// assumes each enable is low while the block pulls its pin low
`default_nettype none

module lac_pin_model (
    input  wire logic alert_out_i, // alert level when driven
    input  wire logic alert_oen_i, // low while driven
    input  wire logic crit_out_i,  // critical level when driven
    input  wire logic crit_oen_i,  // low while driven
    output logic      alert_n_o,   // wire level, pulled up
    output logic      crit_n_o     // wire level, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin goes to the pull-up level, never keeps the last value
    assign alert_n_o = alert_oen_i ? 1'b1 : alert_out_i;
    assign crit_n_o  = crit_oen_i ? 1'b1 : crit_out_i;
endmodule

`default_nettype wire
